/* File: hw/ovp_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ovp_params.svh"
module ovp_top #(
  parameter int unsigned TICK_CYCLES = `OVP_TICK_CYCLES,
  parameter int unsigned NUM_GROUPS  = 4
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  input  wire logic [15:0]        u12_fund_i,
  input  wire logic [15:0]        u23_fund_i,
  input  wire logic [15:0]        u31_fund_i,
  input  wire logic [1:0]         active_group_i,
  input  wire logic               cfg_we_i,
  input  wire logic [1:0]         cfg_stage_i,
  input  wire logic [1:0]         cfg_group_i,
  input  wire ovp_pkg::ovp_set_type cfg_wdata_i,
  output ovp_pkg::ovp_set_type    cfg_rdata_o,
  output logic [2:0]              start_o,
  output logic [2:0]              trip_o,
  output logic                    any_start_o,
  output logic                    any_trip_o,
  output logic [15:0]             max_voltage_o,
  output logic [15:0]             low_op_count_o
);
  import ovp_pkg::*;

  // Stage count is fixed: low, middle and high set.
  localparam int unsigned NSTAGE = 3;

  // Stored groups, the selected group of each stage and the time base.
  ovp_set_type  set_mem_q [NSTAGE][NUM_GROUPS];
  ovp_set_type  cfg_rdata_q;
  ovp_set_type  act_set [NSTAGE];
  logic [31:0]  tick_cnt_q;
  logic         tick_q;
  logic [15:0]  vmax;
  logic [15:0]  vmax_q;
  logic [2:0]   start_q;
  logic [2:0]   trip_q;

  // Stage code 3 addresses nothing; writes to it drop, reads give zero.
  function automatic logic stage_ok(input logic [1:0] stg);
    return stg != `OVP_STAGE_NONE;
  endfunction

  // Start threshold check against one voltage.
  function automatic logic above_start(input logic [15:0] v,
                                       input logic [7:0]  start);
    logic [15:0] th;
    th = 16'(start) * `OVP_V_PER_PCT;
    return v > th;
  endfunction

  // Release check: v below start * (1 - hyst/1000), in integer form.
  function automatic logic below_rel(input logic [15:0] v,
                                     input logic [7:0]  start,
                                     input logic [7:0]  hyst);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(v) * `OVP_PCT_SCALE;
    rhs = 24'(start) * (`OVP_HYST_FULL - 24'(hyst));
    return lhs < rhs;
  endfunction

  // Range limit used for every written setting.
  function automatic logic [15:0] limit(input logic [15:0] val,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    logic [15:0] r;
    r = val;
    if (val < lo) begin
      r = lo;
    end else if (val > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Clamp a written group to the legal ranges of the addressed stage.
  function automatic ovp_set_type fit(input ovp_set_type w,
                                      input logic [1:0]  stg);
    ovp_set_type r;
    logic [15:0] smax;
    logic [15:0] omin;
    r = w;
    smax = (stg == `OVP_STAGE_HIGH) ? 16'(`OVP_START_MAX_H)
                                    : 16'(`OVP_START_MAX_LM);
    case (stg)
      `OVP_STAGE_LOW:  omin = `OVP_OP_MIN_LOW;
      `OVP_STAGE_MID:  omin = `OVP_OP_MIN_MID;
      default:         omin = `OVP_OP_MIN_HIGH;
    endcase
    r.start = 8'(limit(16'(w.start), 16'(`OVP_START_MIN), smax)); // [RULE_09]
    r.hyst  = 8'(limit(16'(w.hyst), 16'(`OVP_HYST_MIN),
                       16'(`OVP_HYST_MAX))); // [RULE_08]
    r.op_dly = limit(w.op_dly, omin, `OVP_DLY_MAX); // [RULE_10]
    // Even codes give the 0.02 s step of the low and middle stages.
    if (stg != `OVP_STAGE_HIGH) begin
      r.op_dly[0] = 1'b0; // [RULE_10]
    end
    // The release delay acts on the low stage only, but is clamped alike.
    r.rel_dly = limit(w.rel_dly, `OVP_REL_MIN, `OVP_DLY_MAX); // [RULE_11]
    r.rel_dly[0] = 1'b0; // [RULE_11]
    return r;
  endfunction

  // Setting storage; every write is forced into range so no stage can
  // run with an illegal delay. The middle and high limit relative to the
  // 160 V measurement range is left to configuration software.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // All groups of all stages wake up on the same default settings.
      for (int s = 0; s < NSTAGE; s++) begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
          set_mem_q[s][g] <= '{start:   `OVP_RST_START,
                               hyst:    `OVP_RST_HYST,
                               op_dly:  `OVP_RST_OP,
                               rel_dly: `OVP_RST_REL};
        end
      end
    end else if (cfg_we_i && stage_ok(cfg_stage_i)) begin
      set_mem_q[cfg_stage_i][cfg_group_i] <= fit(cfg_wdata_i, cfg_stage_i);
    end
  end

  // Readback of the addressed group shows the stored, clamped values.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_q <= '0;
    end else if (!stage_ok(cfg_stage_i)) begin
      cfg_rdata_q <= '0;
    end else begin
      cfg_rdata_q <= set_mem_q[cfg_stage_i][cfg_group_i];
    end
  end

  // Time base: one pulse each 10 ms, shared by all stage timers. The phase
  // runs free, so a delay may come up to one tick short of its setting.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q     <= 1'b0;
    end
  end

  // Highest of the three line-to-line fundamentals; the stage decision
  // only needs the maximum since any one phase above start is enough.
  always_comb begin
    vmax = u12_fund_i; // [RULE_01]
    if (u23_fund_i > vmax) begin
      vmax = u23_fund_i;
    end
    if (u31_fund_i > vmax) begin
      vmax = u31_fund_i;
    end
  end

  // Register the maximum so the compares see a settled value; this costs
  // one cycle of start time, which is far below the tick.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vmax_q <= 16'h0000;
    end else begin
      vmax_q <= vmax;
    end
  end

  // Three definite-time stages, each on its active setting group.
  generate
    for (genvar i = 0; i < NSTAGE; i++) begin : g_stage
      ovp_stage_if sif ();

      // The stage sees only compare results and delays of its active group.
      assign act_set[i]  = set_mem_q[i][active_group_i]; // [RULE_12]
      assign sif.tick    = tick_q;
      assign sif.over    = above_start(vmax_q, act_set[i].start); // [RULE_02]
      assign sif.below   = below_rel(vmax_q, act_set[i].start,
                                     act_set[i].hyst); // [RULE_07]
      assign sif.op_dly  = act_set[i].op_dly;
      assign sif.rel_dly = act_set[i].rel_dly;

      // Only the low stage owns a release timer.
      ovp_stage #(
        .HAS_RELEASE (i == 0) // [RULE_04]
      ) u_stage (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .st        (sif.stage)
      );

      // Start and trip leave through flip-flops; both lag the stage by one
      // edge together, so their order is kept at the pins.
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          start_q[i] <= 1'b0;
          trip_q[i]  <= 1'b0;
        end else begin
          start_q[i] <= sif.start;
          trip_q[i]  <= sif.trip;
        end
      end
    end
  endgenerate

  // Outputs; the low counter is shown so that the retained value of an
  // intermittent fault can be watched from outside.
  assign low_op_count_o = g_stage[0].sif.op_cnt;
  assign cfg_rdata_o    = cfg_rdata_q;
  assign start_o        = start_q;
  assign trip_o         = trip_q;
  assign any_start_o    = |start_q;
  assign any_trip_o     = |trip_q;
  assign max_voltage_o  = vmax_q;
endmodule
`default_nettype wire

/* File: hw/ovp_params.svh */
// How it works
// RULE_01 - Only fundamental line-to-line voltages are compared; no line-to-neutral inputs.
// RULE_02 - A stage starts when any line-to-line voltage exceeds its start setting.
// RULE_03 - A stage trips when the fault lasts for its operate delay.
// RULE_04 - Three definite-time stages: low, middle and high set.
// RULE_05 - Low stage keeps its counter after clearing until release delay elapses.
// RULE_06 - Returning fault before release expiry resumes the low stage counter.
// RULE_07 - Started stage holds until voltage drops below start minus hysteresis.
// RULE_08 - Hysteresis settable 0.1 to 20.0 percent in 0.1 percent steps.
// RULE_09 - Start 50-150 percent low/middle, 50-160 percent high, 1 percent steps.
// RULE_10 - Operate delay up to 300 s; minimum and step differ per stage.
// RULE_11 - Low stage release delay 0.06 s to 300 s in 0.02 s steps.
// RULE_12 - Four setting groups per stage; the active group selects all settings.
// RULE_13 - Software keeps middle/high start within the 160 V measurement limit.
// RULE_14 - Middle and high stages clear counter, start and trip at release.
`ifndef OVP_PARAMS_SVH
`define OVP_PARAMS_SVH

// Timer base: delays are counted in 10 ms units.
`define OVP_CLK_NS          10
`define OVP_TICK_NS         10000000
`define OVP_TICK_CYCLES     (`OVP_TICK_NS / `OVP_CLK_NS)

// Voltage inputs are in 0.1 percent of rated voltage, start in 1 percent.
`define OVP_V_PER_PCT       16'h000A
`define OVP_HYST_FULL       24'h0003E8
`define OVP_PCT_SCALE       24'h000064

// Setting ranges.
`define OVP_START_MIN       8'h32
`define OVP_START_MAX_LM    8'h96
`define OVP_START_MAX_H     8'hA0
`define OVP_HYST_MIN        8'h01
`define OVP_HYST_MAX        8'hC8
`define OVP_DLY_MAX         16'h7530
`define OVP_OP_MIN_LOW      16'h0008
`define OVP_OP_MIN_MID      16'h0006
`define OVP_OP_MIN_HIGH     16'h0004
`define OVP_REL_MIN         16'h0006

// Reset values of every setting group.
`define OVP_RST_START       8'h78
`define OVP_RST_HYST        8'h1E
`define OVP_RST_OP          16'h0064
`define OVP_RST_REL         16'h0006

// Stage indices.
`define OVP_STAGE_LOW       2'h0
`define OVP_STAGE_MID       2'h1
`define OVP_STAGE_HIGH      2'h2
`define OVP_STAGE_NONE      2'h3

`endif

/* File: hw/ovp_pkg.sv */
`default_nettype none
package ovp_pkg;

  // One setting group of one stage.
  typedef struct packed {
    logic [7:0]  start;
    logic [7:0]  hyst;
    logic [15:0] op_dly;
    logic [15:0] rel_dly;
  } ovp_set_type;

  // Operating characteristic; only definite time exists.
  typedef enum logic [0:0] {
    OVP_DEFINITE_TIME_MODE = 1'b0
  } ovp_char_type;

  // Pick-up state of a stage.
  typedef enum logic [1:0] {
    OVP_IDLE    = 2'b00,
    OVP_PICKED  = 2'b01,
    OVP_RELEASE = 2'b10
  } ovp_state_type;

endpackage
`default_nettype wire

/* File: hw/ovp_stage_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ovp_stage_if;
  logic        tick;
  logic        over;
  logic        below;
  logic [15:0] op_dly;
  logic [15:0] rel_dly;
  logic        start;
  logic        trip;
  logic [15:0] op_cnt;

  modport ctrl  (output tick, over, below, op_dly, rel_dly,
                 input start, trip, op_cnt);
  modport stage (input tick, over, below, op_dly, rel_dly,
                 output start, trip, op_cnt);
endinterface
`default_nettype wire

/* File: hw/ovp_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module ovp_stage #(
  parameter bit HAS_RELEASE = 1'b0
) (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  ovp_stage_if.stage  st
);
  import ovp_pkg::*;

  ovp_state_type state_q;
  logic [15:0]   op_cnt_q;
  logic [15:0]   rel_cnt_q;
  logic          trip_q;
  logic          rel_done;

  assign rel_done = (rel_cnt_q >= st.rel_dly);

  // Pick-up with hysteresis: a started stage holds until below release.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= OVP_IDLE;
    end else begin
      case (state_q)
        OVP_IDLE: begin
          if (st.over) begin
            state_q <= OVP_PICKED; // [RULE_02]
          end
        end
        OVP_PICKED: begin
          if (st.below) begin // [RULE_07]
            state_q <= HAS_RELEASE ? OVP_RELEASE : OVP_IDLE; // [RULE_14]
          end
        end
        OVP_RELEASE: begin
          if (st.over) begin
            state_q <= OVP_PICKED; // [RULE_06]
          end else if (rel_done) begin
            state_q <= OVP_IDLE; // [RULE_05]
          end
        end
        default: begin
          state_q <= OVP_IDLE;
        end
      endcase
    end
  end

  // Operate timer; held during release so intermittent faults add up.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_cnt_q <= 16'h0000;
    end else if (state_q == OVP_PICKED) begin
      if (st.tick && (op_cnt_q < st.op_dly)) begin
        op_cnt_q <= op_cnt_q + 16'h0001; // [RULE_03]
      end
    end else if (state_q == OVP_IDLE) begin
      op_cnt_q <= 16'h0000; // [RULE_14]
    end else if (rel_done && !st.over) begin
      op_cnt_q <= 16'h0000; // [RULE_05]
    end
  end

  // Release timer runs only while the low stage waits after a clear.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rel_cnt_q <= 16'h0000;
    end else if (state_q != OVP_RELEASE) begin
      rel_cnt_q <= 16'h0000;
    end else if (st.tick && !rel_done) begin
      rel_cnt_q <= rel_cnt_q + 16'h0001; // [RULE_05]
    end
  end

  // Trip follows the timer while picked and falls on the same edge as the
  // pick-up state, so trip never outlasts start on any stage.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= (state_q == OVP_PICKED) && !st.below && // [RULE_14]
                (op_cnt_q >= st.op_dly); // [RULE_03]
    end
  end

  assign st.start  = (state_q == OVP_PICKED);
  assign st.trip   = trip_q;
  assign st.op_cnt = op_cnt_q;
endmodule
`default_nettype wire

/* File: tb/ovp_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ovp_top_assertions
  import ovp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned NUM_GROUPS  = 4
) (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic [15:0]          u12_fund_i,
  input wire logic [15:0]          u23_fund_i,
  input wire logic [15:0]          u31_fund_i,
  input wire logic [1:0]           cfg_stage_i,
  input wire ovp_pkg::ovp_set_type cfg_rdata_o,
  input wire logic [2:0]           start_o,
  input wire logic [2:0]           trip_o,
  input wire logic                 any_start_o,
  input wire logic                 any_trip_o,
  input wire logic [15:0]          max_voltage_o,
  input wire logic [15:0]          low_op_count_o
);
  // Largest of three magnitudes, written apart from the design's own logic.
  function automatic logic [15:0] vmax3(input logic [15:0] a, b, c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Below 40 % no setting and hysteresis can hold a stage started.
  sequence s_low_v;
    (max_voltage_o < 16'h0190)[*3];
  endsequence

  a_max_of_lines: assert property (1'b1 |=> max_voltage_o ==
    vmax3($past(u12_fund_i), $past(u23_fund_i), $past(u31_fund_i)))
    else $error("maximum voltage does not follow the inputs");
  a_start_cause: assert property ($rose(any_start_o) |->
    $past(max_voltage_o, 2) > 16'h01F4)
    else $error("start without an overvoltage");
  a_low_release: assert property (s_low_v |-> start_o == 3'h0)
    else $error("stage stays started at low voltage");
  a_any_or: assert property (any_start_o == (|start_o) &&
    any_trip_o == (|trip_o))
    else $error("summary outputs disagree with stages");
  a_trip_late: assert property ($rose(trip_o[2]) |->
    $past(start_o[2], 8))
    else $error("high trip too soon after start");
  a_mid_trip_late: assert property ($rose(trip_o[1]) |->
    $past(start_o[1], 8))
    else $error("middle trip too soon after start");
  a_low_trip_count: assert property (trip_o[0] |->
    low_op_count_o >= 16'h0008)
    else $error("low trip below the minimum operate count");
  a_no_stage_read: assert property (cfg_stage_i == 2'h3 |=>
    cfg_rdata_o == '0)
    else $error("readback of the unused stage is not zero");
  a_mid_high_clear: assert property (1'b1 |->
    (trip_o[2:1] & ~start_o[2:1]) == 2'h0)
    else $error("middle or high trip without start");
  a_low_count_hold: assert property (!start_o[0] [*3] |->
    (low_op_count_o == $past(low_op_count_o) || low_op_count_o == 16'h0))
    else $error("low counter moves while released");
endmodule
`default_nettype wire

/* File: tb/ovp_meas_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ovp_meas_model (
  input  wire logic [15:0] level_i,
  input  wire logic [1:0]  sel_i,
  output logic [15:0]      u12_o,
  output logic [15:0]      u23_o,
  output logic [15:0]      u31_o
);
  // Only fundamental line-to-line magnitudes exist here; idle lines sit at
  // rated voltage so a single raised line shows that any one line counts.
  // Code 3 moves all three lines together, so the bench can take every
  // line below the lowest release threshold at once.
  assign u12_o = (sel_i == 2'h0 || sel_i == 2'h3) ? level_i
                                                  : 16'h03E8;
  assign u23_o = (sel_i == 2'h1 || sel_i == 2'h3) ? level_i
                                                  : 16'h03E8;
  assign u31_o = (sel_i == 2'h2 || sel_i == 2'h3) ? level_i
                                                  : 16'h03E8;
endmodule
`default_nettype wire

/* File: tb/ovp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ovp_top_tb;
  import ovp_pkg::*;
  logic        sys_clk_i;
  logic        rst_i;
  logic [15:0] u12, u23, u31, lvl, vmx, lcnt, h;
  logic [1:0]  sel, grp, cst, cgr;
  logic        cwe, ast, atr;
  ovp_set_type cwd, crd;
  logic [2:0]  st, tr;
  int          fails, num_checks;
  // Settings written then read back clamped; rows stay measurable.
  logic [47:0] wd [4] = '{48'h6E1E00090007, 48'hC80000057531,
                          48'hFFFF00030006, 48'h6E1E00640006};
  logic [47:0] ex [4] = '{48'h6E1E00080006, 48'h960100067530,
                          48'hA0C800040006, 48'h0};

  ovp_meas_model u_meas (.level_i(lvl), .sel_i(sel), .u12_o(u12),
                         .u23_o(u23), .u31_o(u31));
  ovp_top #(.TICK_CYCLES(10)) dut (
    .sys_clk_i, .rst_i, .u12_fund_i(u12), .u23_fund_i(u23),
    .u31_fund_i(u31), .active_group_i(grp), .cfg_we_i(cwe),
    .cfg_stage_i(cst), .cfg_group_i(cgr), .cfg_wdata_i(cwd),
    .cfg_rdata_o(crd), .start_o(st), .trip_o(tr), .any_start_o(ast),
    .any_trip_o(atr), .max_voltage_o(vmx), .low_op_count_o(lcnt));

  // Free-running 100 MHz clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // A write is one whole group in a single strobe cycle.
  task automatic wr(input logic [1:0] s, input logic [1:0] g,
                    input ovp_set_type d);
    cst = s;
    cgr = g;
    cwd = d;
    cwe = 1'b1;
    cyc(1);
    cwe = 1'b0;
  endtask
  // Readback lands one edge after the address is set; the check waits two.
  task automatic rd(input logic [1:0] s, input logic [1:0] g,
                    input ovp_set_type e);
    cst = s;
    cgr = g;
    cyc(2);
    chk(crd, e);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole run is about 540 cycles; this limit only catches a hang.
  initial begin
    #20us;
    fails++;
    report_and_stop();
  end

  // Main sequence; inputs move only at falling edges.
  initial begin
    fails = 0;
    num_checks = 0;
    rst_i = 1'b1;
    {cwe, cst, cgr, cwd} = '0;
    grp = 2'h1;
    lvl = 16'h03E8;
    sel = 2'h0;
    cyc(5);
    rst_i = 1'b0;
    rd(2'h0, 2'h0, 48'h781E00640006);
    for (int i = 0; i < 4; i++) begin
      wr(i[1:0], 2'h1, wd[i]);
      rd(i[1:0], 2'h1, ex[i]);
    end
    sel = 2'h1;
    lvl = 16'h0451;
    cyc(4);
    chk(st, 3'h1);
    lvl = 16'h042C;
    cyc(4);
    chk(st, 3'h1);
    lvl = 16'h042A;
    cyc(4);
    chk(st, 3'h0);
    cyc(100);
    chk(lcnt, 16'h0);
    // Intermittent fault: neither burst alone is long enough to trip.
    lvl = 16'h0460;
    cyc(40);
    lvl = 16'h03E8;
    cyc(4);
    h = lcnt;
    cyc(20);
    chk(lcnt, h);
    chk(h != 16'h0, 48'h1);
    lvl = 16'h0460;
    cyc(70);
    chk(tr, 3'h1);
    lvl = 16'h03E8;
    cyc(100);
    chk(lcnt, 16'h0);
    sel = 2'h0;
    lvl = 16'h0641;
    cyc(5);
    chk(st, 3'h7);
    cyc(100);
    chk({ast, atr, tr}, 5'h1F);
    lvl = 16'h03E8;
    cyc(4);
    chk({st, tr}, 6'h0);
    lvl = 16'h05F0;
    cyc(40);
    chk({st[2:1], tr[1]}, 3'h2);
    sel = 2'h1;
    lvl = 16'h047E;
    cyc(5);
    chk(st, 3'h1);
    grp = 2'h0;
    cyc(5);
    chk(st, 3'h0);
    grp = 2'h1;
    cyc(5);
    chk(st, 3'h1);
    sel = 2'h2;
    lvl = 16'h0500;
    cyc(2);
    chk(vmx, 16'h0500);
    // All lines far below every release threshold.
    sel = 2'h3;
    lvl = 16'h0100;
    cyc(5);
    chk(vmx, 16'h0100);
    chk({st, tr}, 6'h00);
    report_and_stop();
  end
endmodule

bind ovp_top ovp_top_assertions #(
  .TICK_CYCLES(TICK_CYCLES),
  .NUM_GROUPS (NUM_GROUPS)
) u_chk (
  .sys_clk_i, .rst_i, .u12_fund_i, .u23_fund_i, .u31_fund_i, .cfg_stage_i,
  .cfg_rdata_o, .start_o, .trip_o, .any_start_o, .any_trip_o,
  .max_voltage_o, .low_op_count_o);
`default_nettype wire
